// File: bench/context_switch_sequencer_bench.sv
`timescale 1ns/1ps
// ==========================================
// Register-level tests of the sequencer
module context_switch_sequencer_bench;
   localparam [15:0] SCORE = 16'h2A5C;
   reg aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, standby_exit, go;
   reg [7:0] s_awaddr, s_araddr;
   reg [31:0] s_wdata, rv;
   reg [3:0] s_wstrb;
   reg [1:0] rr;
   wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, frame_boundary, lens_moving;
   wire hw_update, hw_context_capture, hw_zoom_enable;
   wire [1:0] s_bresp, s_rresp;
   wire [31:0] s_rdata;
   wire [15:0] sharpness_score, hw_out_width, hw_out_height, hw_crop_width, hw_crop_height;
   wire [15:0] hw_zoom_scale;
   wire [4:0] hw_effect;
   wire [7:0] hw_solar_threshold, hw_tint_red_difference, hw_tint_blue_difference;
   wire [7:0] logical_lens_position;
   integer failures, total_checks, i;

   ctxs_sequencer u_dut (.*);
   ctxs_frame_src #(.SCORE(SCORE), .GAP(4'h3)) u_src (.aclk(aclk), .aresetn(aresetn),
      .go(go), .frame_boundary(frame_boundary), .sharpness_score(sharpness_score),
      .lens_moving(lens_moving));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task chk(input string nm, input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task tmo;
      begin
         chk("handshake wait", 0, 1);
         end_of_test;
      end
   endtask

   // Address and data offered together, each released when taken
   task wr(input [7:0] a, input [31:0] d);
      integer n;
      reg aw, w;
      begin
         aw = 0;
         w = 0;
         s_awaddr <= a;
         s_wdata <= d;
         s_awvalid <= 1'b1;
         s_wvalid <= 1'b1;
         s_bready <= 1'b1;
         for (n = 0; !(aw && w); n = n + 1) begin
            @(posedge aclk);
            if (n > 50) tmo;
            if (s_awready && !aw) begin
               aw = 1;
               s_awvalid <= 1'b0;
            end
            if (s_wready && !w) begin
               w = 1;
               s_wvalid <= 1'b0;
            end
         end
         for (n = 0; s_bvalid !== 1'b1; n = n + 1) begin
            @(posedge aclk);
            if (n > 50) tmo;
         end
         rr = s_bresp;
      end
   endtask

   task rd(input [7:0] a);
      integer n;
      begin
         s_araddr <= a;
         s_arvalid <= 1'b1;
         s_rready <= 1'b1;
         for (n = 0; n == 0 || s_arready !== 1'b1; n = n + 1) begin
            @(posedge aclk);
            if (n > 50) tmo;
         end
         s_arvalid <= 1'b0;
         for (n = 0; n == 0 || s_rvalid !== 1'b1; n = n + 1) begin
            @(posedge aclk);
            if (n > 50) tmo;
         end
         rv = s_rdata;
         rr = s_rresp;
      end
   endtask

   // Ask the sensor for one frame end and let the load settle
   task frame;
      integer n;
      begin
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
         for (n = 0; frame_boundary !== 1'b1; n = n + 1) begin
            @(posedge aclk);
            if (n > 20) tmo;
         end
         @(posedge aclk);
         chk("update pulse", hw_update, 1);
         repeat (2) @(posedge aclk);
      end
   endtask

   initial begin
      failures = 0;
      total_checks = 0;
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, standby_exit, go} = 8'h00;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_wdata = 32'h0;
      s_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h44);
      chk("capture crop", rv, 32'h0600_0800);
      rd(8'h1C);
      chk("status init", rv, 32'h01);
      rd(8'h80);
      chk("unmapped resp", rr, 2'h2);
      chk("unmapped data", rv, 32'h0);
      wr(8'h80, 32'h1);
      chk("unmapped wr resp", rr, 2'h2);
      frame;
      chk("preview out", {hw_out_height, hw_out_width}, 32'h0300_0400);
      rd(8'h04);
      chk("state", rv, 32'h03);
      $display("test reset done");
      wr(8'h08, 32'h00);
      wr(8'h40, 32'h0500_0600);
      wr(8'h00, 32'h02);
      rd(8'h04);
      chk("state held", rv, 32'h03);
      rd(8'h00);
      chk("pending cmd", rv, 32'h02);
      chk("context held", hw_context_capture, 0);
      frame;
      chk("context", hw_context_capture, 1);
      chk("capture out", {hw_out_height, hw_out_width}, 32'h0500_0600);
      chk("capture crop hw", {hw_crop_height, hw_crop_width}, 32'h0600_0800);
      rd(8'h04);
      chk("state", rv, 32'h07);
      $display("test capture done");
      for (i = 0; i < 5; i = i + 1) begin
         wr(8'h48, {24'hA0_3008, i[7:0]});
         chk("effect held", hw_effect, (i == 0) ? 1 : 1 << (i - 1));
         wr(8'h00, 32'h06);
         frame;
         chk("effect", hw_effect, 1 << i);
         chk("effect params", {hw_tint_blue_difference, hw_tint_red_difference,
            hw_solar_threshold}, 24'hA0_3008);
      end
      wr(8'h28, 32'h03);
      wr(8'h00, 32'h06);
      frame;
      chk("capture effect", hw_effect, 5'h10);
      $display("test effects done");
      wr(8'h08, 32'h05);
      wr(8'h0C, 32'h20);
      wr(8'h10, 32'hA0);
      wr(8'h20, 32'h00F0_0140);
      wr(8'h00, 32'h01);
      frame;
      chk("preview effect", {hw_context_capture, hw_effect}, 6'h08);
      chk("zoom", {hw_zoom_enable, hw_zoom_scale}, 17'h1_00A0);
      wr(8'h20, 32'h0300_0400);
      wr(8'h00, 32'h05);
      frame;
      chk("zoom off", {hw_zoom_enable, hw_zoom_scale}, 17'h0_0064);
      wr(8'h24, 32'h0300_0500);
      standby_exit <= 1'b1;
      @(posedge aclk);
      standby_exit <= 1'b0;
      frame;
      chk("standby load", hw_crop_width, 16'h0500);
      $display("test zoom done");
      wr(8'h14, 32'h5A);
      chk("lens", logical_lens_position, 8'h5A);
      rd(8'h18);
      chk("sharpness", rv, SCORE);
      $display("test focus done");
      end_of_test;
   end
endmodule // context_switch_sequencer_bench

// File: bench/ctxs_chk.sv
`timescale 1ns/1ps
// ==========================================
// Bus and load-timing checks
module ctxs_chk (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_awvalid,
   input wire s_awready,
   input wire s_wvalid,
   input wire s_wready,
   input wire s_bvalid,
   input wire s_bready,
   input wire [1:0] s_bresp,
   input wire s_arvalid,
   input wire s_arready,
   input wire s_rvalid,
   input wire s_rready,
   input wire [31:0] s_rdata,
   // Frame timing and loaded values
   input wire frame_boundary,
   input wire hw_update,
   input wire hw_context_capture,
   input wire [15:0] hw_out_width,
   input wire [15:0] hw_out_height,
   input wire [15:0] hw_crop_width,
   input wire [15:0] hw_crop_height,
   input wire [4:0] hw_effect,
   input wire hw_zoom_enable,
   input wire [15:0] hw_zoom_scale
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_UPD_LATE: assert property (hw_update |-> $past(frame_boundary))
      else $error("update pulse without frame boundary");
   AST_HW_HOLD: assert property ($changed(hw_out_width) || $changed(hw_effect)
      |-> $past(frame_boundary))
      else $error("hardware value changed mid-frame");
   AST_CTX_UPD: assert property ($changed(hw_context_capture) |-> hw_update)
      else $error("context switch without update pulse");
   AST_FX_ONE: assert property ($onehot(hw_effect))
      else $error("effect not one-hot");
   AST_ZOOM_OFF: assert property (!hw_zoom_enable |-> hw_zoom_scale == 16'h0064)
      else $error("zoom scale set while zoom off");
   AST_ZOOM_SIZE: assert property (hw_zoom_enable |-> hw_out_width < hw_crop_width
      && hw_out_height < hw_crop_height)
      else $error("zoom with output not below crop");
   AST_B_RISE: assert property (s_awvalid && s_awready && s_wvalid && s_wready
      |-> ##2 s_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped");
   AST_R_RISE: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read data late");

   cover property ($rose(hw_context_capture));
   cover property ($fell(hw_context_capture));
   cover property (hw_zoom_enable);
endmodule // ctxs_chk

bind ctxs_sequencer ctxs_chk u_chk (.*);

// File: bench/ctxs_frame_src.sv
`timescale 1ns/1ps
// ==========================================
// Sensor side: frame timing and focus meter
module ctxs_frame_src #(
   parameter [15:0] SCORE = 16'h2A5C,
   parameter [3:0] GAP = 4'h3
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Request for the next frame end
   input wire go,
   // Sensor outputs
   output reg frame_boundary,
   output wire [15:0] sharpness_score,
   output reg lens_moving
);
   reg [3:0] cnt_q;
   reg armed_q;

   assign sharpness_score = SCORE;

   // Boundary only comes GAP+1 cycles after a request, between frames
   always @(posedge aclk) begin
      if (!aresetn) begin
         armed_q <= 1'b0;
         cnt_q <= 4'h0;
         frame_boundary <= 1'b0;
         lens_moving <= 1'b0;
      end else begin
         frame_boundary <= 1'b0;
         if (go) begin
            armed_q <= 1'b1;
            cnt_q <= GAP;
         end else if (armed_q && cnt_q == 4'h0) begin
            armed_q <= 1'b0;
            frame_boundary <= 1'b1;
            lens_moving <= ~lens_moving;
         end else if (armed_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule // ctxs_frame_src

// File: common/ctxs_consts.vh
`ifndef CTXS_CONSTS_VH
`define CTXS_CONSTS_VH

// ==========================================
// Register byte addresses
`define CTXS_A_SEQUENCER_COMMAND 8'h00
`define CTXS_A_SEQUENCER_STATE 8'h04
`define CTXS_A_CAP_FRAMES 8'h08
`define CTXS_A_SYS_MODE 8'h0C
`define CTXS_A_ZOOM 8'h10
`define CTXS_A_LENS 8'h14
`define CTXS_A_SHARP 8'h18
`define CTXS_A_STATUS 8'h1C
`define CTXS_A_CTX0 8'h20
`define CTXS_A_CTX1 8'h40
`define CTXS_O_OUT 8'h00
`define CTXS_O_CROP 8'h04
`define CTXS_O_FX 8'h08

// ==========================================
// Commands, states, field values
`define CTXS_CMD_NONE 8'h00
`define CTXS_CMD_PREVIEW 8'h01
`define CTXS_CMD_CAPTURE 8'h02
`define CTXS_CMD_REFRESH_MODE 8'h05
`define CTXS_CMD_REFRESH 8'h06
`define CTXS_STATE_INIT 8'h00
`define CTXS_STATE_PREVIEW 8'h03
`define CTXS_STATE_CAPTURE 8'h07
`define CTXS_ZOOM_EN_BIT 5
`define CTXS_ZOOM_NONE 16'h0064
`define CTXS_FX_OFF 8'h00
`define CTXS_FX_MONO 8'h01
`define CTXS_FX_SEPIA 8'h02
`define CTXS_FX_NEG 8'h03
`define CTXS_FX_SOLAR 8'h04

// ==========================================
// Reset values of the per-context shadows, and bus response codes
`define CTXS_RST_OUT0 32'h0300_0400
`define CTXS_RST_OUT1 32'h0600_0800
`define CTXS_RST_FX 32'h0000_0000
`define CTXS_RESP_OKAY 2'h0
`define CTXS_RESP_SLVERR 2'h2

`endif

// File: rtl/ctxs_fx_decode.v
`timescale 1ns/1ps
`include "ctxs_consts.vh"

// ==========================================
// Effect selector decode, one bit per effect
module ctxs_fx_decode (
   // Selector
   input wire [7:0] fx_sel,
   // One-hot effect: {solarize, negative, sepia, mono, off}
   output reg [4:0] fx_onehot
);
   always @* begin
      case (fx_sel)
         `CTXS_FX_MONO: fx_onehot = 5'h02;
         `CTXS_FX_SEPIA: fx_onehot = 5'h04;
         `CTXS_FX_NEG: fx_onehot = 5'h08;
         `CTXS_FX_SOLAR: fx_onehot = 5'h10;
         // Unknown codes fall back to no effect rather than a random mix
         default: fx_onehot = 5'h01;
      endcase
   end
endmodule // ctxs_fx_decode

// File: rtl/ctxs_sequencer.v
`timescale 1ns/1ps
`include "ctxs_consts.vh"

// ==========================================
// Context switch sequencer with AXI4-Lite registers
module ctxs_sequencer (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire s_awvalid,
   output reg s_awready,
   input wire [7:0] s_awaddr,
   // AXI4-Lite write data
   input wire s_wvalid,
   output reg s_wready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   // AXI4-Lite write response
   output reg s_bvalid,
   input wire s_bready,
   output reg [1:0] s_bresp,
   // AXI4-Lite read address
   input wire s_arvalid,
   output reg s_arready,
   input wire [7:0] s_araddr,
   // AXI4-Lite read data
   output reg s_rvalid,
   input wire s_rready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   // Frame timing and standby
   input wire frame_boundary,
   input wire standby_exit,
   // Focus measurement
   input wire [15:0] sharpness_score,
   input wire lens_moving,
   // Hardware registers of sensor and image_pipeline
   output reg hw_update,
   output reg hw_context_capture,
   output reg [15:0] hw_out_width,
   output reg [15:0] hw_out_height,
   output reg [15:0] hw_crop_width,
   output reg [15:0] hw_crop_height,
   output reg [4:0] hw_effect,
   output reg [7:0] hw_solar_threshold,
   output reg [7:0] hw_tint_red_difference,
   output reg [7:0] hw_tint_blue_difference,
   output reg hw_zoom_enable,
   output reg [15:0] hw_zoom_scale,
   // Guidance for lens_mechanics_driver
   output reg [7:0] logical_lens_position
);
   localparam [2:0] ST_INIT = 3'b001;
   localparam [2:0] ST_PREVIEW = 3'b010;
   localparam [2:0] ST_CAPTURE = 3'b100;

   // ==========================================
   // Helper functions
   function [31:0] ctxs_merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            ctxs_merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
         end
      end
   endfunction

   function ctxs_mapped;
      input [7:0] addr;
      begin
         case (addr)
            `CTXS_A_SEQUENCER_COMMAND, `CTXS_A_SEQUENCER_STATE, `CTXS_A_CAP_FRAMES, `CTXS_A_SYS_MODE,
            `CTXS_A_ZOOM, `CTXS_A_LENS, `CTXS_A_SHARP, `CTXS_A_STATUS,
            `CTXS_A_CTX0 + `CTXS_O_OUT, `CTXS_A_CTX0 + `CTXS_O_CROP,
            `CTXS_A_CTX0 + `CTXS_O_FX, `CTXS_A_CTX1 + `CTXS_O_OUT,
            `CTXS_A_CTX1 + `CTXS_O_CROP, `CTXS_A_CTX1 + `CTXS_O_FX: ctxs_mapped = 1'b1;
            default: ctxs_mapped = 1'b0;
         endcase
      end
   endfunction

   // ==========================================
   // Write channel capture
   reg aw_full_q;
   reg w_full_q;
   reg [7:0] wr_addr_q;
   reg [31:0] wr_data_q;
   reg [3:0] wr_strb_q;
   wire wr_go = aw_full_q & w_full_q & ~s_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h0000_0000;
         wr_strb_q <= 4'h0;
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= `CTXS_RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_full_q <= 1'b1;
            wr_addr_q <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_full_q <= 1'b1;
            wr_data_q <= s_wdata;
            wr_strb_q <= s_wstrb;
            s_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= ctxs_mapped(wr_addr_q) ? `CTXS_RESP_OKAY : `CTXS_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   // ==========================================
   // Per-context shadow variables
   wire [63:0] sh_out;
   wire [63:0] sh_crop;
   wire [63:0] sh_fx;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ctx_g
         localparam [7:0] BASE = (g == 0) ? `CTXS_A_CTX0 : `CTXS_A_CTX1;
         localparam [31:0] RST_SIZE = (g == 0) ? `CTXS_RST_OUT0 : `CTXS_RST_OUT1;
         reg [31:0] out_q;
         reg [31:0] crop_q;
         reg [31:0] fx_q;
         // Only the shadows move on a write; hardware copies wait for a frame edge
         always @(posedge aclk) begin
            if (!aresetn) begin
               out_q <= RST_SIZE;
               crop_q <= RST_SIZE;
               fx_q <= `CTXS_RST_FX;
            end else if (wr_go) begin
               if (wr_addr_q == BASE + `CTXS_O_OUT) begin
                  out_q <= ctxs_merge(out_q, wr_data_q, wr_strb_q);
               end
               if (wr_addr_q == BASE + `CTXS_O_CROP) begin
                  crop_q <= ctxs_merge(crop_q, wr_data_q, wr_strb_q);
               end
               // Bytes: selector, threshold, red and blue difference
               if (wr_addr_q == BASE + `CTXS_O_FX) begin
                  fx_q <= ctxs_merge(fx_q, wr_data_q, wr_strb_q);
               end
            end
         end
         assign sh_out[32*g +: 32] = out_q;
         assign sh_crop[32*g +: 32] = crop_q;
         assign sh_fx[32*g +: 32] = fx_q;
      end
   endgenerate

   // ==========================================
   // Global variables
   reg [7:0] cap_frames_q;
   reg [7:0] sys_mode_q;
   reg [15:0] zoom_q;
   reg [7:0] pend_cmd_q;
   reg [2:0] state_q;
   reg [7:0] sequencer_state_q;

   wire cmd_wr = wr_go && (wr_addr_q == `CTXS_A_SEQUENCER_COMMAND) && wr_strb_q[0];
   wire [7:0] cmd_val = wr_data_q[7:0];
   wire cmd_ok = (cmd_val == `CTXS_CMD_PREVIEW) || (cmd_val == `CTXS_CMD_CAPTURE) ||
                 (cmd_val == `CTXS_CMD_REFRESH) || (cmd_val == `CTXS_CMD_REFRESH_MODE);
   wire [31:0] zoom_merged = ctxs_merge({16'h0000, zoom_q}, wr_data_q, wr_strb_q);

   always @(posedge aclk) begin
      if (!aresetn) begin
         cap_frames_q <= 8'h00;
         sys_mode_q <= 8'h00;
         zoom_q <= `CTXS_ZOOM_NONE;
         logical_lens_position <= 8'h00;
      end else if (wr_go) begin
         if (wr_addr_q == `CTXS_A_CAP_FRAMES && wr_strb_q[0]) begin
            cap_frames_q <= wr_data_q[7:0];
         end
         if (wr_addr_q == `CTXS_A_SYS_MODE && wr_strb_q[0]) begin
            sys_mode_q <= wr_data_q[7:0];
         end
         if (wr_addr_q == `CTXS_A_ZOOM) begin
            zoom_q <= zoom_merged[15:0];
         end
         // Focus driver firmware steers the lens only through this byte
         if (wr_addr_q == `CTXS_A_LENS && wr_strb_q[0]) begin
            logical_lens_position <= wr_data_q[7:0];
         end
      end
   end

   // ==========================================
   // Target context and its shadow set
   wire apply = frame_boundary && ((pend_cmd_q != `CTXS_CMD_NONE) || (state_q == ST_INIT));
   reg tgt_ctx;

   always @* begin
      case (pend_cmd_q)
         `CTXS_CMD_PREVIEW: tgt_ctx = 1'b0;
         `CTXS_CMD_CAPTURE: tgt_ctx = 1'b1;
         default: tgt_ctx = (state_q == ST_CAPTURE);
      endcase
   end

   wire [31:0] t_out = tgt_ctx ? sh_out[63:32] : sh_out[31:0];
   wire [31:0] t_crop = tgt_ctx ? sh_crop[63:32] : sh_crop[31:0];
   wire [31:0] t_fx = tgt_ctx ? sh_fx[63:32] : sh_fx[31:0];
   wire [4:0] t_fx_onehot;
   wire zoom_ok = sys_mode_q[`CTXS_ZOOM_EN_BIT] &&
                  (t_out[15:0] < t_crop[15:0]) && (t_out[31:16] < t_crop[31:16]);

   ctxs_fx_decode u_fx_decode (
      .fx_sel(t_fx[7:0]),
      .fx_onehot(t_fx_onehot)
   );

   // ==========================================
   // Sequencer: pending command and context state
   always @(posedge aclk) begin
      if (!aresetn) begin
         pend_cmd_q <= `CTXS_CMD_NONE;
         state_q <= ST_INIT;
         sequencer_state_q <= `CTXS_STATE_INIT;
      end else begin
         // A new command in the apply cycle stays pending for the next frame
         if (cmd_wr && cmd_ok) begin
            pend_cmd_q <= cmd_val;
         end else if (apply) begin
            pend_cmd_q <= `CTXS_CMD_NONE;
         end else if (standby_exit && pend_cmd_q == `CTXS_CMD_NONE) begin
            pend_cmd_q <= `CTXS_CMD_REFRESH;
         end
         if (apply) begin
            case (state_q)
               ST_INIT, ST_PREVIEW, ST_CAPTURE: begin
                  state_q <= tgt_ctx ? ST_CAPTURE : ST_PREVIEW;
                  sequencer_state_q <= tgt_ctx ? `CTXS_STATE_CAPTURE : `CTXS_STATE_PREVIEW;
               end
               default: begin
                  state_q <= ST_INIT;
                  sequencer_state_q <= `CTXS_STATE_INIT;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Hardware register upload, only at a frame boundary
   always @(posedge aclk) begin
      if (!aresetn) begin
         hw_update <= 1'b0;
         hw_context_capture <= 1'b0;
         hw_out_width <= 16'h0000;
         hw_out_height <= 16'h0000;
         hw_crop_width <= 16'h0000;
         hw_crop_height <= 16'h0000;
         hw_effect <= 5'h01;
         hw_solar_threshold <= 8'h00;
         hw_tint_red_difference <= 8'h00;
         hw_tint_blue_difference <= 8'h00;
         hw_zoom_enable <= 1'b0;
         hw_zoom_scale <= `CTXS_ZOOM_NONE;
      end else begin
         hw_update <= apply;
         // Copy the whole set at once so no frame sees a half-updated mode
         if (apply) begin
            hw_context_capture <= tgt_ctx;
            hw_out_width <= t_out[15:0];
            hw_out_height <= t_out[31:16];
            hw_crop_width <= t_crop[15:0];
            hw_crop_height <= t_crop[31:16];
            hw_effect <= t_fx_onehot;
            hw_solar_threshold <= t_fx[15:8];
            hw_tint_red_difference <= t_fx[23:16];
            hw_tint_blue_difference <= t_fx[31:24];
            hw_zoom_enable <= zoom_ok;
            hw_zoom_scale <= zoom_ok ? zoom_q : `CTXS_ZOOM_NONE;
         end
      end
   end

   // ==========================================
   // Read channel
   reg [31:0] rd_mux;

   always @* begin
      case (s_araddr)
         `CTXS_A_SEQUENCER_COMMAND: rd_mux = {24'h000000, pend_cmd_q};
         `CTXS_A_SEQUENCER_STATE: rd_mux = {24'h000000, sequencer_state_q};
         `CTXS_A_CAP_FRAMES: rd_mux = {24'h000000, cap_frames_q};
         `CTXS_A_SYS_MODE: rd_mux = {24'h000000, sys_mode_q};
         `CTXS_A_ZOOM: rd_mux = {16'h0000, zoom_q};
         `CTXS_A_LENS: rd_mux = {24'h000000, logical_lens_position};
         // Score from sharpness_meter, read by the focus driver firmware
         `CTXS_A_SHARP: rd_mux = {16'h0000, sharpness_score};
         `CTXS_A_STATUS: rd_mux = {27'h0000000, hw_zoom_enable, lens_moving,
                                   (pend_cmd_q != `CTXS_CMD_NONE), hw_context_capture,
                                   (state_q == ST_INIT)};
         `CTXS_A_CTX0 + `CTXS_O_OUT: rd_mux = sh_out[31:0];
         `CTXS_A_CTX0 + `CTXS_O_CROP: rd_mux = sh_crop[31:0];
         `CTXS_A_CTX0 + `CTXS_O_FX: rd_mux = sh_fx[31:0];
         `CTXS_A_CTX1 + `CTXS_O_OUT: rd_mux = sh_out[63:32];
         `CTXS_A_CTX1 + `CTXS_O_CROP: rd_mux = sh_crop[63:32];
         `CTXS_A_CTX1 + `CTXS_O_FX: rd_mux = sh_fx[63:32];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `CTXS_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= rd_mux;
         s_rresp <= ctxs_mapped(s_araddr) ? `CTXS_RESP_OKAY : `CTXS_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

endmodule // ctxs_sequencer
